//--- rtl/stdr_bank.sv
// Sleep timer, offset converter control, serial number and part identifier registers
`include "stdr_regs.svh"
module stdr_bank
	import stdr_pkg::*;
#(
	parameter logic [63:0] STEP_CYCLES = `STDR_STEP_CYCLES, // Cycles in one four hour step
	parameter logic [31:0] SERIAL_NO   = 32'h0000_0000,     // Arbitrary neutral value
	parameter logic [7:0]  PART_ID     = 8'h00              // Arbitrary neutral value
) (
	input  wire logic       clk_sys_i,     // 250 MHz system clock
	input  wire logic       srst_i,        // Synchronous reset, high
	input  wire logic       ce_i,          // Clock enable, freezes all state low
	input  wire stdr_req_t  req_i,         // Register access from the slave engine
	input  wire logic       wake_cmd_i,    // Wake command decoded by the slave engine
	input  wire logic       cmp1_i,        // Comparator output, channel one (pin)
	input  wire logic       cmp2_i,        // Comparator output, channel two (pin)
	input  wire logic       adaptive_i,    // High in adaptive threshold mode
	input  wire logic [1:0] range_i,       // Selected capacitive input range
	input  wire stdr_avg_t  avg1_i,        // Averaged data, channel one
	input  wire stdr_avg_t  avg2_i,        // Averaged data, channel two
	output logic [7:0]      rdata_o,       // Read data
	output logic            rvalid_o,      // Read data valid, one-cycle pulse
	output logic [7:0]      dac1_o,        // Offset register, channel one
	output logic [7:0]      dac2_o,        // Offset register, channel two
	output logic            power_down_o,  // Analog circuits powered down
	output logic [2:0]      mode_o         // Mode code forced while asleep
);
	localparam logic [15:0] UPPER_Q = 16'hC000; // Three quarters of full range
	localparam logic [15:0] LOWER_Q = 16'h4000; // One quarter of full range

	stdr_state_t cur_ff;   // Registered state
	stdr_state_t nxt_cur;  // Next state

	// Step size grows with input range; wider range needs coarser offset steps
	function automatic logic [5:0] track_step(input logic [1:0] rng);
		track_step = 6'h01 << rng;
	endfunction

	// Saturating tracking update of one offset register
	function automatic logic [7:0] track(input logic [7:0] dac, input stdr_avg_t a,
		input logic adapt, input logic [1:0] rng);
		logic [6:0] sum;
		logic [5:0] st;
		st = track_step(rng);
		track = dac;
		sum = 7'h00;
		if (a.valid && adapt && dac[`STDR_BIT_AUTO_TRACK] && dac[`STDR_BIT_DAC_ON]) begin
			if (a.avg > UPPER_Q) begin
				sum = {1'b0, dac[5:0]} + {1'b0, st};
				track[5:0] = sum[6] ? 6'h3F : sum[5:0];
			end else if (a.avg < LOWER_Q) begin
				track[5:0] = (dac[5:0] < st) ? 6'h00 : dac[5:0] - st;
			end
		end
	endfunction

	// Next state: register writes, reads, tracking and sleep timer
	always_comb begin
		logic act;
		logic rewrite;
		act = 1'b0;
		rewrite = 1'b0;
		nxt_cur = cur_ff;
		nxt_cur.rvalid = 1'b0;
		// Three-stage pin sampling, activity taken when stages two and three are both high
		nxt_cur.cmp1_s = {cur_ff.cmp1_s[1:0], cmp1_i};
		nxt_cur.cmp2_s = {cur_ff.cmp2_s[1:0], cmp2_i};
		act = (cur_ff.cmp1_s[2] & cur_ff.cmp1_s[1]) | (cur_ff.cmp2_s[2] & cur_ff.cmp2_s[1]);
		// tracking acts on the six-bit linear code
		nxt_cur.dac1 = track(cur_ff.dac1, avg1_i, adaptive_i, range_i);
		nxt_cur.dac2 = track(cur_ff.dac2, avg2_i, adaptive_i, range_i);
		// register writes from the slave engine
		if (req_i.wr) begin
			unique case (req_i.addr)
				`STDR_ADDR_SLEEP: begin
					nxt_cur.sleep = req_i.wdata;
					rewrite = 1'b1;
				end
				`STDR_ADDR_DAC1: nxt_cur.dac1 = req_i.wdata;
				`STDR_ADDR_DAC2: nxt_cur.dac2 = req_i.wdata;
				default: ;
			endcase
		end
		// Reads answer one cycle later; unknown addresses read zero
		if (req_i.rd) begin
			nxt_cur.rvalid = 1'b1;
			unique case (req_i.addr)
				`STDR_ADDR_SLEEP:   nxt_cur.rdata = cur_ff.sleep;
				`STDR_ADDR_DAC1:    nxt_cur.rdata = cur_ff.dac1;
				`STDR_ADDR_DAC2:    nxt_cur.rdata = cur_ff.dac2;
				// serial number, most significant byte first
				`STDR_ADDR_SER0:    nxt_cur.rdata = SERIAL_NO[31:24];
				`STDR_ADDR_SER1:    nxt_cur.rdata = SERIAL_NO[23:16];
				`STDR_ADDR_SER2:    nxt_cur.rdata = SERIAL_NO[15:8];
				`STDR_ADDR_SER3:    nxt_cur.rdata = SERIAL_NO[7:0];
				`STDR_ADDR_PART_ID: nxt_cur.rdata = PART_ID;
				default:            nxt_cur.rdata = 8'h00;
			endcase
		end
		if (act || rewrite || cur_ff.sleep[`STDR_TMO_MSB:0] == 6'h00) begin
			nxt_cur.tick = 48'h0000_0000_0000;
			nxt_cur.hours4 = 6'h00;
		end else if (cur_ff.pwr == STDR_RUN) begin
			if (cur_ff.tick == STEP_CYCLES[47:0] - 48'h0000_0000_0001) begin
				nxt_cur.tick = 48'h0000_0000_0000;
				nxt_cur.hours4 = cur_ff.hours4 + 6'h01;
			end else begin
				nxt_cur.tick = cur_ff.tick + 48'h0000_0000_0001;
			end
		end
		if (cur_ff.pwr == STDR_RUN && cur_ff.sleep[`STDR_TMO_MSB:0] != 6'h00
			&& cur_ff.hours4 == cur_ff.sleep[`STDR_TMO_MSB:0] && !act && !rewrite) begin
			nxt_cur.pwr = STDR_ASLEEP;
		end
		// serial wake; power cycle comes as reset
		if (wake_cmd_i) begin
			nxt_cur.pwr = STDR_RUN;
			nxt_cur.tick = 48'h0000_0000_0000;
			nxt_cur.hours4 = 6'h00;
		end
		// Output flags registered together with the power state
		nxt_cur.pdn = (nxt_cur.pwr == STDR_ASLEEP);
		nxt_cur.mode = nxt_cur.pdn ? `STDR_MODE_POWERDOWN : 3'h0;
	end

	// State register with clock enable
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			cur_ff <= '0;
			cur_ff.sleep <= `STDR_SLEEP_RST;
			cur_ff.dac1 <= `STDR_DAC_RST;
			cur_ff.dac2 <= `STDR_DAC_RST;
			cur_ff.pwr <= STDR_RUN;
		end else if (ce_i) begin
			cur_ff <= nxt_cur;
		end
	end

	// Outputs straight from the state register
	assign rdata_o = cur_ff.rdata;
	assign rvalid_o = cur_ff.rvalid;
	// enable bit travels with the code
	assign dac1_o = cur_ff.dac1;
	assign dac2_o = cur_ff.dac2;
	// Power flags are flops of their own so no decode logic sits on the pins
	assign power_down_o = cur_ff.pdn;
	assign mode_o = cur_ff.mode;

	// Sleep register resets to its preset
	property p_sleep_rst;
		@(posedge clk_sys_i) srst_i |=> cur_ff.sleep == 8'h40;
	endproperty
	a_sleep_rst: assert property (p_sleep_rst) else $error("sleep reset wrong");

	// Offset registers reset to preset
	property p_dac_rst;
		@(posedge clk_sys_i) srst_i |=> (dac1_o == 8'hC0 && dac2_o == 8'hC0);
	endproperty
	a_dac_rst: assert property (p_dac_rst) else $error("offset reset wrong");

	// Zero timeout never sleeps
	property p_no_sleep_zero;
		@(posedge clk_sys_i) disable iff (srst_i)
			(ce_i && !power_down_o && cur_ff.sleep[5:0] == 6'h00) |=> !power_down_o;
	endproperty
	a_no_sleep_zero: assert property (p_no_sleep_zero) else $error("slept with zero");

	// Wake command returns to run
	property p_wake;
		@(posedge clk_sys_i) disable iff (srst_i) (ce_i && wake_cmd_i) |=> !power_down_o;
	endproperty
	a_wake: assert property (p_wake) else $error("wake ignored");

	// Power-down shows mode 011
	property p_mode;
		@(posedge clk_sys_i) disable iff (srst_i) power_down_o |-> mode_o == 3'h3;
	endproperty
	a_mode: assert property (p_mode) else $error("mode code wrong");

	// Fixed threshold mode keeps code still without writes
	property p_fixed;
		@(posedge clk_sys_i) disable iff (srst_i)
			(ce_i && !adaptive_i && !req_i.wr) |=> dac1_o == $past(dac1_o);
	endproperty
	a_fixed: assert property (p_fixed) else $error("tracked in fixed mode");

	// High average raises code
	property p_up;
		@(posedge clk_sys_i) disable iff (srst_i)
			(ce_i && !req_i.wr && adaptive_i && avg1_i.valid && avg1_i.avg > 16'hC000
			&& dac1_o[7:6] == 2'b11 && dac1_o[5:0] == 6'h00) |=> dac1_o[5:0] != 6'h00;
	endproperty
	a_up: assert property (p_up) else $error("no increment");

	// Low average lowers code
	property p_down;
		@(posedge clk_sys_i) disable iff (srst_i)
			(ce_i && !req_i.wr && adaptive_i && avg1_i.valid && avg1_i.avg < 16'h4000
			&& dac1_o[7:6] == 2'b11 && dac1_o[5:0] == 6'h3F) |=> dac1_o[5:0] < 6'h3F;
	endproperty
	a_down: assert property (p_down) else $error("no decrement");

	// Serial number write has no effect
	property p_ro;
		@(posedge clk_sys_i) disable iff (srst_i)
			(ce_i && req_i.wr && req_i.addr == 8'h13) |=> cur_ff.sleep == $past(cur_ff.sleep);
	endproperty
	a_ro: assert property (p_ro) else $error("read-only write landed");

	// Clock enable low freezes the visible state
	property p_ce_freeze;
		@(posedge clk_sys_i) disable iff (srst_i)
			!ce_i |=> (dac1_o == $past(dac1_o) && power_down_o == $past(power_down_o));
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("state moved without enable");

	// Every read is answered one cycle later
	property p_rd_ans;
		@(posedge clk_sys_i) disable iff (srst_i) (ce_i && req_i.rd) |=> rvalid_o;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");

	// Channel two write lands in its own register
	property p_wr_dac2;
		@(posedge clk_sys_i) disable iff (srst_i)
			(ce_i && req_i.wr && req_i.addr == 8'h12) |=> dac2_o == $past(req_i.wdata);
	endproperty
	a_wr_dac2: assert property (p_wr_dac2) else $error("channel two write lost");

	// Channel two also holds still in fixed threshold mode
	property p_fixed2;
		@(posedge clk_sys_i) disable iff (srst_i)
			(ce_i && !adaptive_i && !req_i.wr) |=> dac2_o == $past(dac2_o);
	endproperty
	a_fixed2: assert property (p_fixed2) else $error("channel two tracked in fixed");

	// Part identifier read returns the parameter
	property p_pid_rd;
		@(posedge clk_sys_i) disable iff (srst_i)
			(ce_i && req_i.rd && req_i.addr == 8'h17) |=> rdata_o == PART_ID;
	endproperty
	a_pid_rd: assert property (p_pid_rd) else $error("identifier read wrong");

	// Top serial byte comes first
	property p_ser_rd;
		@(posedge clk_sys_i) disable iff (srst_i)
			(ce_i && req_i.rd && req_i.addr == 8'h13) |=> rdata_o == SERIAL_NO[31:24];
	endproperty
	a_ser_rd: assert property (p_ser_rd) else $error("serial read wrong");

	// A channel with its converter off is never tracked
	property p_off_hold;
		@(posedge clk_sys_i) disable iff (srst_i)
			(ce_i && !req_i.wr && !dac1_o[7]) |=> dac1_o == $past(dac1_o);
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("tracked while off");
endmodule // stdr_bank

//--- rtl/stdr_pkg.sv
// Types shared by the sleep timer and offset converter register bank
package stdr_pkg;
	// One register access from the serial slave engine
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} stdr_req_t;
	// Averaged conversion result of one channel with its strobe
	typedef struct packed {
		logic        valid;
		logic [15:0] avg;
	} stdr_avg_t;
	// Power state of the part
	typedef enum logic {
		STDR_RUN,
		STDR_ASLEEP
	} stdr_pwr_t;
	// Whole state of the bank
	typedef struct packed {
		logic [7:0]  sleep;
		logic [7:0]  dac1;
		logic [7:0]  dac2;
		logic [7:0]  rdata;
		logic        rvalid;
		logic [47:0] tick;
		logic [5:0]  hours4;
		stdr_pwr_t   pwr;
		logic        pdn;
		logic [2:0]  mode;
		logic [2:0]  cmp1_s;
		logic [2:0]  cmp2_s;
	} stdr_state_t;
endpackage

//--- rtl/stdr_regs.svh
// Register offsets, field positions, reset values and timing counts of the sleep/offset bank
`ifndef STDR_REGS_SVH
`define STDR_REGS_SVH
`define STDR_ADDR_SLEEP      8'h10
`define STDR_ADDR_DAC1       8'h11
`define STDR_ADDR_DAC2       8'h12
`define STDR_ADDR_SER0       8'h13
`define STDR_ADDR_SER1       8'h14
`define STDR_ADDR_SER2       8'h15
`define STDR_ADDR_SER3       8'h16
`define STDR_ADDR_PART_ID    8'h17
`define STDR_SLEEP_RST       8'h40
`define STDR_DAC_RST         8'hC0
`define STDR_BIT_MUST_ZERO   7
`define STDR_BIT_MUST_ONE    6
`define STDR_BIT_DAC_ON      7
`define STDR_BIT_AUTO_TRACK  6
`define STDR_TMO_MSB         5
`define STDR_MODE_POWERDOWN  3'h3
`define STDR_STEP_HOURS      4
`define STDR_CLK_HZ          250000000
`define STDR_STEP_CYCLES     (64'd3600 * 64'd`STDR_STEP_HOURS * 64'd`STDR_CLK_HZ)
`endif

//--- verification/stdr_host.sv
// Host model that issues register accesses toward the bank
module stdr_host
	import stdr_pkg::*;
(
	input  wire logic       clk_sys_i, // System clock
	input  wire logic [7:0] rdata_i,   // Read data from the bank
	input  wire logic       rvalid_i,  // Read data valid pulse
	output stdr_req_t       req_o      // Access toward the bank
);
	timeunit 1ns;
	timeprecision 100ps;
	initial req_o = '0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		if (a == 8'h10) d = {2'b01, d[5:0]};
		@(posedge clk_sys_i);
		#1 req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys_i);
		// Released fields invert so stale values are never trusted
		#1 req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	// Read; data is taken in the one cycle the valid pulse stands
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		#1 req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_sys_i);
		#1 req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
		d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
	endtask
endmodule // stdr_host

//--- verification/testbench.sv
// Self-checking bench for the sleep timer and offset register bank
module testbench
	import stdr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [63:0] STEP = 64'h0000_0000_0000_000A; // Short step keeps the run brief
	localparam logic [31:0] SER  = 32'h1234_5678;           // Arbitrary serial value
	localparam logic [7:0]  PID  = 8'h5A;                   // Arbitrary identifier value
	logic        clk_sys_i, srst_i, wake, cmp1, cmp2, adapt, rvalid, pdn, ce; // Bench signals
	logic [1:0]  rng;                // Input range select
	stdr_req_t   req;                // Access from the host model
	stdr_avg_t   avg1, avg2;         // Averaged data strobes
	logic [7:0]  rdata, dac1, dac2, v; // Bank outputs and read result
	logic [2:0]  mode;               // Mode code
	logic [7:0]  exp_tab [8];        // Expected bytes at 0x10..0x17
	int          n_mismatch, n_compared, cyc; // Counters
	stdr_bank #(.STEP_CYCLES(STEP), .SERIAL_NO(SER), .PART_ID(PID)) stdr_bank_inst (
		.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce), .req_i(req), .wake_cmd_i(wake),
		.cmp1_i(cmp1), .cmp2_i(cmp2), .adaptive_i(adapt), .range_i(rng), .avg1_i(avg1),
		.avg2_i(avg2), .rdata_o(rdata), .rvalid_o(rvalid), .dac1_o(dac1), .dac2_o(dac2),
		.power_down_o(pdn), .mode_o(mode));
	stdr_host stdr_host_inst (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .rvalid_i(rvalid),
		.req_o(req));
	// Free-running clock, 4 ns period
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	// Hang guard; the tests need far fewer cycles
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	// One averaged-data strobe on channel one, then let the update land
	task automatic avg_hit(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk_sys_i);
		#1 avg1 = '{valid: 1'b1, avg: a};
		@(posedge clk_sys_i);
		#1 avg1 = '{valid: 1'b0, avg: ~a};
		tick(1);
		chk("dac1_o", dac1, exp);
	endtask
	task automatic complete_run();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		{wake, cmp1, cmp2, adapt, rng, v, n_mismatch, n_compared, cyc} = '0;
		avg1 = '0;
		avg2 = '0;
		ce = 1'b1;
		srst_i = 1'b1;
		exp_tab = '{8'h40, 8'hC0, 8'hC0, SER[31:24], SER[23:16], SER[15:8], SER[7:0], PID};
		tick(4);
		srst_i = 1'b0;
		// Reset values, read-only bytes, writes to them ignored, unmapped read
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 8; i++) begin
				stdr_host_inst.rd(8'h10 + 8'(i), v);
				chk("reg byte", v, exp_tab[i]);
				if (i > 2) stdr_host_inst.wr(8'h10 + 8'(i), 8'hFF);
			end
		end
		stdr_host_inst.rd(8'h20, v);
		chk("unmapped", v, 8'h00);
		$display("test registers done");
		// Offset tracking: steps, range, thresholds, modes, clock enable hold, auto-track off
		adapt = 1'b1;
		avg_hit(16'hC001, 8'hC1);
		rng = 2'h2;
		avg_hit(16'hC001, 8'hC5);
		avg_hit(16'h3FFF, 8'hC1);
		avg_hit(16'hC000, 8'hC1);
		avg_hit(16'h4000, 8'hC1);
		adapt = 1'b0;
		avg_hit(16'hC001, 8'hC1);
		adapt = 1'b1;
		ce = 1'b0;
		avg_hit(16'hC001, 8'hC1);
		ce = 1'b1;
		stdr_host_inst.wr(8'h11, 8'h81);
		avg_hit(16'hFFFF, 8'h81);
		stdr_host_inst.wr(8'h11, 8'h3F);
		stdr_host_inst.rd(8'h11, v);
		chk("dac1 code", v, 8'h3F);
		chk("dac2_o", dac2, 8'hC0);
		$display("test tracking done");
		// Sleep after one step, wake by command, zero disables
		stdr_host_inst.wr(8'h10, 8'h01);
		for (int i = 0; i < 60 && pdn !== 1'b1; i++) tick(1);
		chk("power_down_o", {7'h00, pdn}, 8'h01);
		chk("mode_o", {5'h00, mode}, 8'h03);
		@(posedge clk_sys_i);
		#1 wake = 1'b1;
		tick(1);
		wake = 1'b0;
		tick(2);
		chk("woken", {4'h0, mode, pdn}, 8'h00);
		stdr_host_inst.wr(8'h10, 8'h00);
		tick(200);
		chk("never sleeps", {7'h00, pdn}, 8'h00);
		// Comparator held high on one channel or the other keeps a two-step timeout alive
		stdr_host_inst.wr(8'h10, 8'h02);
		repeat (6) begin
			tick(12);
			{cmp1, cmp2} = 2'b01;
			tick(4);
			{cmp1, cmp2} = 2'b10;
		end
		cmp1 = 1'b0;
		chk("kept awake", {7'h00, pdn}, 8'h00);
		for (int i = 0; i < 60 && pdn !== 1'b1; i++) tick(1);
		chk("sleeps later", {7'h00, pdn}, 8'h01);
		$display("test sleep done");
		complete_run();
	end
endmodule // testbench
